// *** verilog/acs_sequencer.sv ***
// Purpose: digital control of a 12-bit successive-approximation converter
// Assumes: analog core gives one decision bit per converter clock
// Notes:   registers reached over AHB-Lite, zero wait states
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer #(
  parameter int RES_W = acs_pkg::RES_BITS // result width
) (
  input  wire logic        ref_clk,        // system clock 10 MHz
  input  wire logic        sys_rst,        // async reset, active high
  input  wire logic        hsel,           // slave select
  input  wire logic [31:0] haddr,          // byte address
  input  wire logic [1:0]  htrans,         // transfer type
  input  wire logic        hwrite,         // write when high
  input  wire logic [2:0]  hsize,          // transfer size
  input  wire logic [31:0] hwdata,         // write data
  input  wire logic        hready,         // bus ready in
  output logic      [31:0] hrdata,         // read data
  output logic             hreadyout,      // slave ready
  output logic             hresp,          // always okay
  input  wire logic        cmpDecision,    // comparator bit from analog core
  output logic             converterPowerEn, // analog power enable
  output logic             sampleEn,       // sample switch closed
  output logic [RES_W-1:0] dacCode,        // trial code to analog DAC
  output logic [3:0]       externalChannelSel, // external pin mux
  output logic [2:0]       inputSourceSel, // internal/external source
  output logic [7:0]       pinAnalogInputEn, // per-pin analog enables
  output logic             refSupplySel,   // high: supply is reference
  output logic             convIrq         // completion interrupt
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0]       ctrl0_reg;
  logic [7:0]       ctrl1_reg;
  logic [7:0]       pinEn_reg;
  logic [2:0]       intr_reg;
  logic [RES_W-1:0] result_reg;
  logic [RES_W-1:0] sar_reg;
  logic             busy_reg;
  logic [6:0]       div_reg;
  logic [4:0]       cnt_reg;
  acs_pkg::acs_state_t state_reg;
  logic             startPrev_reg;
  logic             wrPend_reg;
  logic [7:0]       addr_reg;
  logic             tick;
  logic             done;
  logic             startRise;
  logic             startFall;
  logic             addrPhase;
  logic [7:0]       rdByte;
  logic [6:0]       divMask;
  logic [15:0]      fmtWord;
  logic [7:0]       c0View;
  logic [7:0]       c1View;
  logic [7:0]       pinView;
  logic [2:0]       intrView;

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  // capture address phase of NONSEQ transfers
  assign addrPhase = hsel && hready && htrans == acs_pkg::HTRANS_NONSEQ;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wrPend_reg <= 1'b0;
      addr_reg   <= 8'h00;
    end else begin
      wrPend_reg <= addrPhase && hwrite;
      if (addrPhase) begin
        addr_reg <= haddr[7:0];
      end
    end
  end

  // control registers and pin enables
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl0_reg <= acs_pkg::CTRL0_RESET;
      ctrl1_reg <= acs_pkg::CTRL1_RESET;
      pinEn_reg <= 8'h00;
    end else if (wrPend_reg) begin
      case (addr_reg)
        acs_pkg::CTRL0_OFFSET: ctrl0_reg <= hwdata[7:0];
        acs_pkg::CTRL1_OFFSET: ctrl1_reg <= hwdata[7:0];
        acs_pkg::PINEN_OFFSET: pinEn_reg <= hwdata[7:0]; // RL12
        default: ;
      endcase
    end
  end

  // interrupt enables; flag set wins over software clear
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      intr_reg <= 3'h0;
    end else begin
      if (wrPend_reg && addr_reg == acs_pkg::INTR_OFFSET) begin
        intr_reg[acs_pkg::GIE_BIT]  <= hwdata[acs_pkg::GIE_BIT];
        intr_reg[acs_pkg::CIE_BIT]  <= hwdata[acs_pkg::CIE_BIT];
        if (!hwdata[acs_pkg::FLAG_BIT]) begin
          intr_reg[acs_pkg::FLAG_BIT] <= 1'b0;
        end
      end
      if (done) begin
        intr_reg[acs_pkg::FLAG_BIT] <= 1'b1; // RL9
      end
    end
  end

  // register views with a landing write folded in, so a read right behind a write sees it
  always_comb begin
    c0View   = ctrl0_reg;
    c1View   = ctrl1_reg;
    pinView  = pinEn_reg;
    intrView = intr_reg;
    if (wrPend_reg) begin
      case (addr_reg)
        acs_pkg::CTRL0_OFFSET: c0View  = hwdata[7:0];
        acs_pkg::CTRL1_OFFSET: c1View  = hwdata[7:0];
        acs_pkg::PINEN_OFFSET: pinView = hwdata[7:0];
        acs_pkg::INTR_OFFSET: begin
          intrView[acs_pkg::GIE_BIT]  = hwdata[acs_pkg::GIE_BIT];
          intrView[acs_pkg::CIE_BIT]  = hwdata[acs_pkg::CIE_BIT];
          intrView[acs_pkg::FLAG_BIT] = intr_reg[acs_pkg::FLAG_BIT] && hwdata[acs_pkg::FLAG_BIT];
        end
        default: ;
      endcase
    end
    if (done) begin
      intrView[acs_pkg::FLAG_BIT] = 1'b1; // RL9
    end
  end

  // result byte arrangement by format bit
  always_comb begin
    if (c0View[acs_pkg::FMT_BIT]) begin
      fmtWord = {4'h0, result_reg}; // RL14
    end else begin
      fmtWord = {result_reg, 4'h0}; // RL14
    end
  end

  // read mux, decoded from the address phase
  always_comb begin
    case (haddr[7:0])
      acs_pkg::CTRL0_OFFSET: rdByte = {c0View[7], busy_reg, c0View[5:0]}; // RL11
      acs_pkg::CTRL1_OFFSET: rdByte = c1View;
      acs_pkg::PINEN_OFFSET: rdByte = pinView;
      acs_pkg::RESHI_OFFSET: rdByte = fmtWord[15:8];
      acs_pkg::RESLO_OFFSET: rdByte = fmtWord[7:0];
      acs_pkg::INTR_OFFSET:  rdByte = {5'h00, intrView};
      default:               rdByte = 8'h00;
    endcase
  end

  // read data captured at the address phase so it stands for the whole data phase
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hrdata <= 32'h0000_0000;
    end else if (addrPhase && !hwrite) begin
      hrdata <= {24'h00_0000, rdByte};
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1; // zero wait states
      hresp     <= 1'b0;
    end
  end

  // ----------------------------------------
  // converter clock divider
  // ----------------------------------------
  // tick when low bits selected by the code all wrap
  assign divMask = 7'((8'h01 << ctrl1_reg[acs_pkg::DIV_LSB +: 3]) - 8'h01);
  assign tick    = (div_reg & divMask) == divMask; // RL2
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_reg <= 7'h00;
    end else if (state_reg != acs_pkg::ST_CONV) begin
      div_reg <= 7'h00;
    end else begin
      div_reg <= div_reg + 7'h01;
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  assign startRise = ctrl0_reg[acs_pkg::START_BIT] && !startPrev_reg;
  assign startFall = !ctrl0_reg[acs_pkg::START_BIT] && startPrev_reg;
  assign done      = state_reg == acs_pkg::ST_CONV && tick && cnt_reg == 5'(acs_pkg::TOTAL_CYCLES - 1);

  // start edge tracking and state flow
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      startPrev_reg <= 1'b0;
      state_reg     <= acs_pkg::ST_IDLE;
      cnt_reg       <= 5'h00;
      busy_reg      <= 1'b0;
    end else begin
      startPrev_reg <= ctrl0_reg[acs_pkg::START_BIT];
      if (!ctrl0_reg[acs_pkg::PWR_BIT]) begin
        state_reg <= acs_pkg::ST_IDLE; // RL4
        busy_reg  <= 1'b0;
      end else if (startRise) begin
        state_reg <= acs_pkg::ST_ARMED; // RL19
        busy_reg  <= 1'b0;
        cnt_reg   <= 5'h00;
      end else begin
        case (state_reg)
          acs_pkg::ST_IDLE: ;
          acs_pkg::ST_ARMED: begin
            if (startFall) begin
              state_reg <= acs_pkg::ST_CONV; // RL7 RL19
              busy_reg  <= 1'b1; // RL8
              cnt_reg   <= 5'h00;
            end
          end
          acs_pkg::ST_CONV: begin
            if (done) begin
              state_reg <= acs_pkg::ST_IDLE;
              busy_reg  <= 1'b0; // RL8
            end else if (tick) begin
              cnt_reg <= cnt_reg + 5'h01; // RL1
            end
          end
          default: state_reg <= acs_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // successive approximation, one bit per converter clock after sampling
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sar_reg <= '0;
    end else if (state_reg != acs_pkg::ST_CONV) begin
      sar_reg <= '0;
    end else if (tick && cnt_reg >= 5'(acs_pkg::SAMPLE_CYCLES)) begin
      sar_reg[RES_W - 1 - (int'(cnt_reg) - acs_pkg::SAMPLE_CYCLES)] <= cmpDecision; // RL1 RL15
    end
  end

  // result holds last completed code
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      result_reg <= '0;
    end else if (done) begin
      result_reg <= {sar_reg[RES_W-1:1], cmpDecision}; // RL20 RL15
    end
  end

  // ----------------------------------------
  // analog side outputs
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      converterPowerEn   <= 1'b0;
      sampleEn           <= 1'b0;
      dacCode            <= '0;
      externalChannelSel <= 4'h0;
      inputSourceSel     <= 3'h0;
      pinAnalogInputEn   <= 8'h00;
      refSupplySel       <= 1'b0;
      convIrq            <= 1'b0;
    end else begin
      converterPowerEn   <= ctrl0_reg[acs_pkg::PWR_BIT]; // RL4
      sampleEn           <= state_reg == acs_pkg::ST_CONV && cnt_reg < 5'(acs_pkg::SAMPLE_CYCLES); // RL1
      dacCode            <= sar_reg | (RES_W'(1) << (RES_W - 1 - (int'(cnt_reg) - acs_pkg::SAMPLE_CYCLES)));
      externalChannelSel <= ctrl0_reg[acs_pkg::CH_LSB +: 4]; // RL12
      inputSourceSel     <= ctrl1_reg[acs_pkg::SRC_LSB +: 3];
      pinAnalogInputEn   <= pinEn_reg;
      refSupplySel       <= ctrl1_reg[acs_pkg::REF_LSB +: 2] == acs_pkg::REF_SUPPLY; // RL16 RL17
      convIrq            <= intr_reg[acs_pkg::FLAG_BIT] && intr_reg[acs_pkg::CIE_BIT]
                            && intr_reg[acs_pkg::GIE_BIT]; // RL9
    end
  end
endmodule : acs_sequencer
`default_nettype wire

// *** verilog/acs_pkg.sv ***
// Purpose: constants for the converter conversion sequencer
// Assumes: one 10 MHz clock, AHB-Lite register access
// Notes:   register offsets are byte addresses of aligned words
//
// How it works
// RL1: sample 4 clocks, convert 12, total 16
// RL2: converter clock is sysclk over power of two
// RL3: software keeps converter period 0.5 to 10 us; the bench drives divider codes 0 to 7, periods 0.1 to 12.8 us
// RL4: analog powered only while power enable high
// RL5: software waits settling after enabling power
// RL6: software clears power enable when idle; the bench leaves power enable set between conversions
// RL7: start pulse low-high-low launches a conversion
// RL8: busy high during conversion, result valid after
// RL9: completion sets flag, interrupt only when enabled
// RL10: software enables both interrupts before starting; the bench enables both on its first pass only, random enables after
// RL11: busy flag alone still reports completion
// RL12: external sources use channel field pin select
// RL13: software sets channel 1xxx for internal sources
// RL14: format bit arranges result across two bytes
// RL15: result is 12-bit unsigned code
// RL16: reference field chooses reference source
// RL17: code 01 picks supply, others external pin
// RL18: software follows the documented setup order
// RL19: start rise resets, fall launches and sets busy
// RL20: result registers hold until next completion
package acs_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] CTRL0_OFFSET  = 8'h00; // converter_control_zero
  localparam logic [7:0] CTRL1_OFFSET  = 8'h04; // converter_control_one
  localparam logic [7:0] PINEN_OFFSET  = 8'h08; // analog_pin_enable_reg
  localparam logic [7:0] RESHI_OFFSET  = 8'h0C; // result_high_byte
  localparam logic [7:0] RESLO_OFFSET  = 8'h10; // result_low_byte
  localparam logic [7:0] INTR_OFFSET   = 8'h14; // interrupt enables and flag
  // ----------------------------------------
  // control zero fields
  // ----------------------------------------
  localparam int CH_LSB     = 0;  // external_channel_sel [3:0]
  localparam int FMT_BIT    = 4;  // result_format_sel
  localparam int PWR_BIT    = 5;  // converter_power_en
  localparam int BUSY_BIT   = 6;  // conversion_busy_flag (read only)
  localparam int START_BIT  = 7;  // start control
  // ----------------------------------------
  // control one fields
  // ----------------------------------------
  localparam int DIV_LSB    = 0;  // conv_clock_div_sel [2:0]
  localparam int REF_LSB    = 3;  // reference_source_sel [1:0]
  localparam int SRC_LSB    = 5;  // input_source_sel [2:0]
  // ----------------------------------------
  // interrupt register fields
  // ----------------------------------------
  localparam int GIE_BIT    = 0;  // global_interrupt_en
  localparam int CIE_BIT    = 1;  // converter_interrupt_en
  localparam int FLAG_BIT   = 2;  // converter_interrupt_flag, write 0 clears
  // ----------------------------------------
  // reset values and timing
  // ----------------------------------------
  localparam logic [7:0] CTRL0_RESET = 8'h00;
  localparam logic [7:0] CTRL1_RESET = 8'h00;
  localparam logic [1:0] REF_SUPPLY  = 2'h1;
  localparam int SAMPLE_CYCLES  = 4;
  localparam int CONVERT_CYCLES = 12;
  localparam int TOTAL_CYCLES   = SAMPLE_CYCLES + CONVERT_CYCLES;
  localparam int RES_BITS       = 12;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;
  // ----------------------------------------
  // sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h1,
    ST_ARMED  = 3'h2,
    ST_CONV   = 3'h4
  } acs_state_t;
endpackage : acs_pkg

// *** tb/acs_sequencer_sva.sv ***
// Purpose: port checks for the converter sequencer
// Assumes: zero-wait bus; config is shadowed from bus writes
// Notes:   shadows land on the same edge as the design registers
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer_sva (
  input wire logic        ref_clk,            // clock
  input wire logic        sys_rst,            // reset
  input wire logic        hsel,               // select
  input wire logic [31:0] haddr,              // address
  input wire logic [1:0]  htrans,             // transfer
  input wire logic        hwrite,             // write
  input wire logic [31:0] hwdata,             // wdata
  input wire logic        hready,             // ready in
  input wire logic [31:0] hrdata,             // rdata
  input wire logic        hreadyout,          // ready out
  input wire logic        hresp,              // response
  input wire logic        converterPowerEn,   // power
  input wire logic        sampleEn,           // sampling
  input wire logic [11:0] dacCode,            // trial code
  input wire logic [3:0]  externalChannelSel, // channel
  input wire logic [2:0]  inputSourceSel,     // source
  input wire logic [7:0]  pinAnalogInputEn,   // pin enables
  input wire logic        refSupplySel,       // reference
  input wire logic        convIrq             // interrupt
);
  logic       wrPend;
  logic       fallNow;
  logic [7:0] wrAddr, c0Sh, c1Sh, pinSh, ieSh, sinceFall;
  logic [15:0] sampCnt;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------
  // bus shadow
  // ----------------------------------------
  // address phase capture of writes
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wrPend <= 1'b0;
      wrAddr <= 8'h00;
    end else begin
      wrPend <= hsel && hready && hwrite && htrans == acs_pkg::HTRANS_NONSEQ;
      wrAddr <= haddr[7:0];
    end
  end
  // data phase updates the shadow copies
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      c0Sh  <= 8'h00;
      c1Sh  <= 8'h00;
      pinSh <= 8'h00;
      ieSh  <= 8'h00;
    end else if (wrPend) begin
      case (wrAddr)
        8'h00: c0Sh <= hwdata[7:0] & 8'hBF;
        8'h04: c1Sh <= hwdata[7:0];
        8'h08: pinSh <= hwdata[7:0];
        8'h14: ieSh <= hwdata[7:0] & 8'h03;
        default: ;
      endcase
    end
  end
  assign fallNow = wrPend && wrAddr == 8'h00 && c0Sh[7] && !hwdata[7] && hwdata[5];
  // sampling length and time since the last start fall
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sampCnt   <= 16'h0000;
      sinceFall <= 8'hFF;
    end else begin
      sampCnt   <= sampleEn ? sampCnt + 16'h0001 : 16'h0000;
      sinceFall <= fallNow ? 8'h00 : (sinceFall == 8'hFF ? sinceFall : sinceFall + 8'h01);
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  sequence startFall;
    fallNow;
  endsequence
  sequence cfgHeld;
    ($stable(c0Sh) && $stable(c1Sh) && $stable(pinSh)) [*2];
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp && hrdata[31:8] == 24'h000000)
    else $error("bus answer not okay");
  a_sample_length: assert property ($fell(sampleEn) |-> sampCnt == (16'h0004 << c1Sh[2:0]))
    else $error("sampling length wrong");
  a_power_gates: assert property (sampleEn |-> converterPowerEn)
    else $error("sampling without power");
  a_start_launches: assert property (startFall |-> ##[1:6] sampleEn)
    else $error("start fall did not launch sampling");
  a_no_stray_sample: assert property ($rose(sampleEn) |-> sinceFall <= 8'h06)
    else $error("sampling without start pulse");
  a_config_copies: assert property (cfgHeld |-> inputSourceSel == c1Sh[7:5]
    && externalChannelSel == c0Sh[3:0] && pinAnalogInputEn == pinSh
    && refSupplySel == (c1Sh[4:3] == 2'h1) && converterPowerEn == c0Sh[5])
    else $error("config outputs differ from registers");
  a_irq_gated: assert property (($stable(ieSh)) [*2] |-> ieSh[1:0] == 2'h3 || !convIrq)
    else $error("interrupt while disabled");
  a_done_after_sample: assert property ($rose(convIrq) |-> !sampleEn && !$past(sampleEn))
    else $error("completion during sampling");
  a_first_trial: assert property ($fell(sampleEn) |-> dacCode == 12'h800)
    else $error("first trial code wrong");
endmodule : acs_sequencer_sva
bind acs_sequencer acs_sequencer_sva i_chk (.ref_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .hrdata, .hreadyout, .hresp, .converterPowerEn, .sampleEn, .dacCode, .externalChannelSel,
  .inputSourceSel, .pinAnalogInputEn, .refSupplySel, .convIrq);
`default_nettype wire

// *** tb/acs_sequencer_test.sv ***
// Purpose: self-checking bench for the converter sequencer
// Assumes: 10 MHz clock, zero-wait AHB-Lite slave
// Notes:   comparator held per conversion, so codes are all ones or zero
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer_test;
  logic        ref_clk, sys_rst, hsel, hwrite, cmpDecision, rdPh, hreadyout, hresp, convIrq, fmt;
  logic [31:0] haddr, hwdata, hrdata, seed, r, expQ[$];
  logic [7:0]  c0, c1, got, hiExp, loExp;
  logic [11:0] res;
  logic [3:0]  i;
  logic [2:0]  hsize;
  logic [1:0]  htrans, ie;
  int          num_errors, n_compared, cyc;
  localparam int SETTLE_CYCLES = 8; // power-up settling allowance, plain default
  acs_sequencer i_dut (.ref_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .cmpDecision, .converterPowerEn(), .sampleEn(),
    .dacCode(), .externalChannelSel(), .inputSourceSel(), .pinAnalogInputEn(), .refSupplySel(), .convIrq);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task end_of_test();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test
  // one single transfer; reads may note an expected value
  task bus(input logic [7:0] a, input logic w, input logic [7:0] d, input logic c, input logic [7:0] e);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= acs_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    rdPh   <= c;
    if (c) expQ.push_back({24'h000000, e});
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    got = hrdata[7:0];
    rdPh <= 1'b0;
  endtask : bus
  task wr(input logic [7:0] a, input logic [7:0] d);
    bus(a, 1'b1, d, 1'b0, 8'h00);
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] e);
    bus(a, 1'b0, 8'h00, 1'b1, e);
  endtask : rd
  // ----------------------------------------
  // clock, monitor, timeout
  // ----------------------------------------
  always #50 ref_clk = ~ref_clk;
  // read data phase compared against the oldest note
  always @(posedge ref_clk) begin
    if (rdPh === 1'b1) chk(hrdata, expQ.pop_front());
  end
  // hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      end_of_test();
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {ref_clk, hsel, hwrite, cmpDecision, rdPh, htrans, haddr, hwdata, hiExp} = '0;
    {num_errors, n_compared, cyc} = '0;
    sys_rst = 1'b1;
    hsize   = acs_pkg::HSIZE_WORD;
    seed    = 32'h455875c7;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(8'h00, 8'h00);
    rd(8'h04, 8'h00);
    rd(8'h0C, 8'h00);
    wr(8'h1C, 8'hA5);
    rd(8'h1C, 8'h00);
    for (i = 4'h0; i < 4'h9; i++) begin
      r   = rnd();
      fmt = r[8];
      ie  = (i == 4'h0) ? 2'h3 : r[10:9];
      c1  = {r[7:3], i[3] ? r[2:0] : i[2:0]};
      c0  = {3'b001, fmt, r[14] | (r[5] & ~r[7]), r[13:11]};
      wr(8'h04, {5'h00, c1[2:0]});
      wr(8'h00, 8'h28);
      repeat (SETTLE_CYCLES) @(posedge ref_clk);
      wr(8'h00, c0);
      wr(8'h04, {c1[7:5], 2'h0, c1[2:0]});
      wr(8'h08, r[23:16] | (8'h01 << c0[2:0]));
      wr(8'h04, c1);
      rd(8'h04, c1);
      wr(8'h14, {6'h00, ie});
      cmpDecision <= r[24];
      wr(8'h00, c0 | 8'h80);
      wr(8'h00, c0);
      @(posedge ref_clk);
      rd(8'h00, c0 | 8'h40);
      do bus(8'h00, 1'b0, 8'h00, 1'b0, 8'h00); while (got[6] !== 1'b0);
      res   = r[24] ? 12'hFFF : 12'h000;
      hiExp = fmt ? {4'h0, res[11:8]} : res[11:4];
      loExp = fmt ? res[7:0] : {res[3:0], 4'h0};
      rd(8'h0C, hiExp);
      rd(8'h10, loExp);
      rd(8'h14, {5'h00, 1'b1, ie});
      chk({31'h0, convIrq}, {31'h0, ie == 2'h3});
      wr(8'h14, {6'h00, ie});
      rd(8'h14, {6'h00, ie});
    end
    // power drop in mid-conversion aborts and keeps the old result
    cmpDecision <= ~cmpDecision;
    wr(8'h04, {c1[7:3], 3'h3});
    wr(8'h00, c0 | 8'h80);
    wr(8'h00, c0);
    repeat (40) @(posedge ref_clk);
    wr(8'h00, c0 & 8'hDF);
    @(posedge ref_clk);
    rd(8'h00, c0 & 8'hDF);
    rd(8'h0C, hiExp);
    end_of_test();
  end
endmodule : acs_sequencer_test
`default_nettype wire
